// ==== pce_map.svh ====
// Contract
// - detect on ports one to three, fifth pin3
// - every pin configurable on its own
// - request only while master enable set
// - flags still update with master clear
// - separate rising and falling detectors
// - rising detect needs rising enable bit
// - falling detect needs falling enable bit
// - both enables detect either direction
// - enabled edge sets sticky pin flag
// - summary flag is OR of flags
// - writing zero clears a flag
// - edge during clear keeps flag set
// - wake from sleep when master enabled
// - sleep edge updates flags before wake
// - registers eight bits, reset to zero
`ifndef PCE_MAP_SVH
`define PCE_MAP_SVH
`define PCE_PORT_W 8
`define PCE_NUM_PORTS 4
`define PCE_FIFTH_PIN 3
`define PCE_RESET_VAL 8'h00
`define PCE_FIFTH_MASK 8'h08
`endif

// ==== pce_pins.sv ====
`timescale 1ns/1ns
module pce_pins (
  // clock and pins
  input wire logic clk_i,
  output pce_pkg::pce_ports_t pins_o
);
  initial pins_o = '0;
  // levels change just after an edge, like a real asynchronous source
  task automatic drive(input int p, input int b, input logic v);
    @(posedge clk_i);
    pins_o.val[p][b] <= v;
  endtask
endmodule // pce_pins

// ==== pce_pkg.sv ====
package pce_pkg;
  typedef logic [7:0] pce_byte_t;
  // index 0..2 are the first three ports, index 3 the fifth port
  typedef struct packed {
    pce_byte_t [3:0] val;
  } pce_ports_t;
  typedef struct packed {
    logic [1:0] port;
    pce_byte_t data;
    logic strobe;
  } pce_wr_t;
  typedef enum logic [1:0] {
    PCE_REG_RISE,
    PCE_REG_FALL,
    PCE_REG_FLAG,
    PCE_REG_NONE
  } pce_reg_t;
endpackage

// ==== pce_top.sv ====
`timescale 1ns/1ns
`include "pce_map.svh"
module pce_top #(
  parameter int PORT_W = `PCE_PORT_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // pins
  input wire pce_pkg::pce_ports_t PIN_I,
  // register writes, master enable and sleep
  input wire pce_pkg::pce_reg_t WR_SEL_I,
  input wire pce_pkg::pce_wr_t WR_I,
  input wire logic MASTER_EN_I,
  input wire logic SLEEP_I,
  // status
  output pce_pkg::pce_ports_t RISE_EN_O,
  output pce_pkg::pce_ports_t FALL_EN_O,
  output pce_pkg::pce_ports_t FLAG_O,
  output logic SUMMARY_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  import pce_pkg::*;

  // the mask and flag logic is written for byte-wide ports only
  generate
    if (PORT_W != 8)
    begin : g_bad_width
      $error("PORT_W must be 8");
    end
  endgenerate

  // ****************************
  // reset release
  // ****************************
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ****************************
  // pin synchronisers
  // ****************************
  // which pins can ever raise a change; unused bits of the fifth port stay dead
  function automatic pce_byte_t pce_mask(input int p);
    pce_mask = (p == 3) ? `PCE_FIFTH_MASK : 8'hff;
  endfunction

  pce_ports_t s1;
  pce_ports_t s2;
  pce_ports_t s3;
  pce_ports_t prev;
  pce_ports_t next_prev;
  pce_ports_t rise_p;
  pce_ports_t fall_p;
  always_comb
  begin
    next_prev = prev;
    for (int p = 0; p < `PCE_NUM_PORTS; p++)
      if (s2.val[p] == s3.val[p])
        next_prev.val[p] = s3.val[p];
  end
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      prev <= '0;
    end
    else
    begin
      s1 <= PIN_I;
      s2 <= s1;
      s3 <= s2;
      prev <= next_prev;
    end
  end

  // ****************************
  // edge detection and flags
  // ****************************
  pce_ports_t next_rise;
  pce_ports_t next_fall;
  pce_ports_t next_flag;
  pce_ports_t hit;
  logic next_summary;
  logic next_irq;
  logic next_wake;
  genvar g;
  generate
    for (g = 0; g < `PCE_NUM_PORTS; g++)
    begin : g_edge
      // separate detectors per direction, each gated by its own enable bit
      assign rise_p.val[g] = next_prev.val[g] & ~prev.val[g] & pce_mask(g);
      assign fall_p.val[g] = ~next_prev.val[g] & prev.val[g] & pce_mask(g);
      assign hit.val[g] = (rise_p.val[g] & RISE_EN_O.val[g])
                        | (fall_p.val[g] & FALL_EN_O.val[g]);
    end
  endgenerate

  always_comb
  begin
    next_rise = RISE_EN_O;
    next_fall = FALL_EN_O;
    next_flag = FLAG_O;
    if (WR_I.strobe)
    begin
      unique case (WR_SEL_I)
        PCE_REG_RISE: next_rise.val[WR_I.port] = WR_I.data & pce_mask(WR_I.port);
        PCE_REG_FALL: next_fall.val[WR_I.port] = WR_I.data & pce_mask(WR_I.port);
        PCE_REG_FLAG: next_flag.val[WR_I.port] = WR_I.data & FLAG_O.val[WR_I.port];
        PCE_REG_NONE: ;
      endcase
    end
    // set wins over a clearing write; also works asleep, clock keeps running
    next_flag = next_flag | hit;
    next_summary = |next_flag;
    next_irq = next_summary & MASTER_EN_I;
    next_wake = next_summary & MASTER_EN_I & SLEEP_I;
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      RISE_EN_O <= '0;
      FALL_EN_O <= '0;
      FLAG_O <= '0;
      SUMMARY_O <= 1'b0;
      IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
    end
    else
    begin
      RISE_EN_O <= next_rise;
      FALL_EN_O <= next_fall;
      FLAG_O <= next_flag;
      SUMMARY_O <= next_summary;
      IRQ_O <= next_irq;
      WAKE_O <= next_wake;
    end
  end

  // ****************************
  // checks
  // ****************************
  AST_IRQ_GATED: assert property (@(posedge CLK_I) disable iff (!rst_n)
    IRQ_O |-> $past(MASTER_EN_I))
    else $error("irq without master enable");
  AST_SUMMARY_OR: assert property (@(posedge CLK_I) disable iff (!rst_n)
    SUMMARY_O == (|FLAG_O))
    else $error("summary not OR of flags");
  AST_SET_WINS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (|hit) |=> ((FLAG_O & $past(hit)) == $past(hit)))
    else $error("edge lost");
  AST_FIFTH_ONLY: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (FLAG_O.val[3] & ~`PCE_FIFTH_MASK) == 8'h00)
    else $error("bad fifth pin");
  AST_NO_SPURIOUS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (hit == '0 && !WR_I.strobe) |=> FLAG_O == $past(FLAG_O))
    else $error("flag moved");
  AST_CLEAR: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (WR_I.strobe && WR_SEL_I == PCE_REG_FLAG && WR_I.data == 8'h00
     && hit.val[WR_I.port] == 8'h00) |=> FLAG_O.val[$past(WR_I.port)] == 8'h00)
    else $error("clear failed");
  AST_WAKE: assert property (@(posedge CLK_I) disable iff (!rst_n)
    WAKE_O |-> IRQ_O)
    else $error("wake without irq");
  AST_RISE_EN: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (rise_p.val[0][0] && !fall_p.val[0][0] && !RISE_EN_O.val[0][0]) |-> !hit.val[0][0])
    else $error("rise without enable");
  AST_FALL_EN: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (fall_p.val[0][0] && !FALL_EN_O.val[0][0]) |-> !hit.val[0][0])
    else $error("fall without enable");
  AST_EDGE_LAT: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s2.val[0][0] && s3.val[0][0] && !prev.val[0][0] && RISE_EN_O.val[0][0]) |=> FLAG_O.val[0][0])
    else $error("edge not flagged");
  AST_IRQ_SET: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ((|next_flag) && MASTER_EN_I) |=> IRQ_O)
    else $error("irq missing");
  AST_IRQ_OFF: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !MASTER_EN_I |=> !IRQ_O)
    else $error("irq while master clear");
  AST_FLAG_NO_MASTER: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!MASTER_EN_I && (|hit)) |=> SUMMARY_O)
    else $error("flag not kept with master clear");
  AST_WAKE_SET: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ((|next_flag) && MASTER_EN_I && SLEEP_I) |=> WAKE_O)
    else $error("wake missing");
  AST_WAKE_AWAKE: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !SLEEP_I |=> !WAKE_O)
    else $error("wake while awake");
  AST_RISE_MASK: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (RISE_EN_O.val[3] & ~`PCE_FIFTH_MASK) == 8'h00)
    else $error("bad fifth rise enable");
  AST_FALL_MASK: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (FALL_EN_O.val[3] & ~`PCE_FIFTH_MASK) == 8'h00)
    else $error("bad fifth fall enable");
  AST_WR_NO_SET: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (WR_I.strobe && hit == '0) |=> (FLAG_O & ~$past(FLAG_O)) == '0)
    else $error("write set a flag");
  AST_FALL_LAT: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!s2.val[0][0] && !s3.val[0][0] && prev.val[0][0] && FALL_EN_O.val[0][0]) |=> FLAG_O.val[0][0])
    else $error("fall not flagged");
  AST_EN_WRITE: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (WR_I.strobe && WR_SEL_I == PCE_REG_RISE && WR_I.port == 2'h0) |=> RISE_EN_O.val[0] == $past(WR_I.data))
    else $error("enable write lost");
  AST_EDGE_PULSE: assert property (@(posedge CLK_I) disable iff (!rst_n)
    rise_p.val[0][0] |=> !rise_p.val[0][0])
    else $error("edge pulse too long");
endmodule // pce_top

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import pce_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pce_reg_t sel = PCE_REG_NONE;
  pce_wr_t wr = '0;
  logic men = 1'b0;
  logic slp = 1'b0;
  pce_ports_t pin, rise, fall, flag;
  logic sum, irq, wake;
  int failures = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  pce_pins pins (.clk_i(clk), .pins_o(pin));
  pce_top dut (.CLK_I(clk), .RESETN_I(rst_n), .PIN_I(pin), .WR_SEL_I(sel), .WR_I(wr),
    .MASTER_EN_I(men), .SLEEP_I(slp), .RISE_EN_O(rise), .FALL_EN_O(fall),
    .FLAG_O(flag), .SUMMARY_O(sum), .IRQ_O(irq), .WAKE_O(wake));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input pce_reg_t s, input logic [1:0] p, input pce_byte_t d);
    @(posedge clk);
    sel <= s;
    wr <= '{p, d, 1'b1};
    @(posedge clk);
    sel <= PCE_REG_NONE;
    wr.strobe <= 1'b0;
  endtask
  // pin to flag takes about four edges, six leaves margin
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    check(flag, 32'h0);
    check({rise, fall}, 64'h0);
    check({sum, irq, wake}, 3'h0);
  endtask
  task automatic t_enable;
    wr_reg(PCE_REG_RISE, 2'h3, 8'hff);
    wr_reg(PCE_REG_FALL, 2'h0, 8'h80);
    wr_reg(PCE_REG_RISE, 2'h0, 8'h01);
    wait_n(1);
    check(rise.val[3], 8'h08);
    check(rise.val[0], 8'h01);
    check(fall.val[0], 8'h80);
  endtask
  task automatic t_edges;
    pins.drive(0, 7, 1'b1);
    pins.drive(0, 0, 1'b1);
    wait_n(6);
    check(flag.val[0], 8'h01);
    check({sum, irq}, 2'h2);
    @(posedge clk);
    men <= 1'b1;
    wait_n(3);
    check(irq, 1'b1);
    pins.drive(0, 7, 1'b0);
    pins.drive(0, 0, 1'b0);
    wait_n(6);
    check(flag.val[0], 8'h81);
    @(posedge clk);
    slp <= 1'b1;
    wait_n(3);
    check(wake, 1'b1);
  endtask
  task automatic t_clear;
    wr_reg(PCE_REG_FLAG, 2'h0, 8'h7f);
    wait_n(1);
    check(flag.val[0], 8'h01);
    wr_reg(PCE_REG_FLAG, 2'h0, 8'h00);
    wait_n(2);
    check({flag, sum, irq, wake}, 35'h0);
  endtask
  // clearing write lands on the same edge as the detected rise
  task automatic t_race;
    pins.drive(3, 3, 1'b1);
    wait_n(6);
    check(flag.val[3], 8'h08);
    pins.drive(0, 0, 1'b1);
    repeat (2) @(posedge clk);
    wr_reg(PCE_REG_FLAG, 2'h0, 8'h00);
    wait_n(1);
    check(flag.val[0], 8'h01);
  endtask
  task automatic results;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(4);
    t_reset();
    t_enable();
    t_edges();
    t_clear();
    t_race();
    results();
  end
  // whole run is about sixty cycles
  initial
  begin
    #20000;
    failures++;
    results();
  end
endmodule // testbench
